// >>> rtl/lpcmb_regs.vh
// Constants of the host mailbox data and status registers.
// Assumes slave offsets are 5-bit word indexes on the internal register port.
`ifndef LPCMB_REGS_VH
`define LPCMB_REGS_VH

// Slave offset groups, bits [4:2] of the slave address; the bidirectional group is bit 4 alone
`define LPCMB_GRP_IN      3'h0
`define LPCMB_GRP_OUT     3'h1
`define LPCMB_GRP_FLAGS   3'h2
`define LPCMB_A_ARB       5'h0c
`define LPCMB_GRP_BIDIR   1'b1
`define LPCMB_BIDIR_LEAD  4'h0
`define LPCMB_BIDIR_LAST  4'hf

// Channel flag register field positions
`define LPCMB_F_OUT_FULL  0
`define LPCMB_F_IN_FULL   1
`define LPCMB_F_USER_TWO  2
`define LPCMB_F_CMD       3
`define LPCMB_F_USER_LO   4
`define LPCMB_F_USER_HI   7

// Host I/O address bit that selects flags on read, command on write
`define LPCMB_A_CMD_BIT   2

// Reset values
`define LPCMB_FLAGS_RST   8'h00
`define LPCMB_USER_RST    5'h00

`endif

// >>> rtl/lpcmb_fifo.v
// Synchronous FIFO buffering host write cycles ahead of the register file.
// Assumes one clock, synchronous active-low reset.
`timescale 1ns/1ps

module lpcmb_fifo #(
  parameter WIDTH = 15,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             nrst,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_q;
  reg [AW-1:0]    rd_ptr_q;
  reg [AW:0]      count_q;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready  = (count_q != DEPTH[AW:0]);
  assign out_valid = (count_q != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_q];

  // Storage carries no reset, only the pointers and the count need one
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap naturally; DEPTH must be a power of two
  always @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push & ~pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop & ~push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule

// >>> rtl/lpcmb_top.v
// Host mailbox data, bidirectional and channel flag registers.
// Assumes an outside decoder has matched the LPC I/O address to a channel
// or to the bidirectional window and hands over one-cycle read/write strobes.
`timescale 1ns/1ps
`include "lpcmb_regs.vh"

// Behaviour
// RULE1: Four 8-bit output bytes; slave reads and writes, host only reads.
// RULE2: Host read with address bit 2 low returns the channel output byte.
// RULE3: Output and bidirectional bytes have no reset value.
// RULE4: Sixteen 8-bit bidirectional bytes readable and writable by both sides.
// RULE5: Byte 0 is two registers: host-to-slave and slave-to-host.
// RULE6: Both writers check arbitration flags after writing byte 0; only the slave can read them (LPCMB_A_ARB), the host cannot.
// RULE7: Host write stores into bidirectional byte; host read returns it.
// RULE8: Host read with address bit 2 high returns the channel flags.
// RULE9: Flag bits 7..4 and 2 are user bits, slave writable, reset zero.
// RULE10: Flag bit 3 captures address bit 2 on host input write.
// RULE11: Input full set by host input write, cleared by slave read.
// RULE12: Input full flag requests a slave interrupt.
// RULE13: Output full set by slave output write, cleared by host read.
// RULE14: Slave clears output full only by writing zero; one ignored.
// RULE15: Host input write stores byte and latches address bit 2.
// RULE16: Channel 2 (and every channel) keeps the same flag behaviour.
// RULE17: Command bit and input full update with the stored byte.
module lpcmb_top #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input  wire        clk,
  input  wire        nrst,
  // Host side, decoded I/O cycles
  input  wire        host_wr,
  output wire        host_wr_ready,
  input  wire        host_rd,
  output wire        host_rd_ready,
  input  wire        host_bidir,
  input  wire [1:0]  host_chan,
  input  wire [3:0]  host_addr,
  input  wire [7:0]  host_wdata,
  output reg  [7:0]  host_rdata_q,
  output reg         host_rvalid_q,
  // Slave side, internal register access
  input  wire        slv_wr,
  input  wire        slv_rd,
  input  wire [4:0]  slv_addr,
  input  wire [7:0]  slv_wdata,
  output reg  [7:0]  slv_rdata_q,
  output reg         slv_rvalid_q,
  // Input full flags towards the slave interrupt controller
  output wire [3:0]  slave_irq_req
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg  [7:0]  host_input_byte  [0:3];
  reg  [7:0]  host_output_byte [0:3];
  reg  [7:0]  shared_bidir_byte [1:15];
  reg  [7:0]  host_to_slave_lead_byte;
  reg  [7:0]  slave_to_host_lead_byte;
  reg  [3:0]  input_full_flag_q;
  reg  [3:0]  output_full_flag_q;
  reg  [3:0]  command_not_data_q;
  reg  [4:0]  user_flags_q [0:3];
  reg         host_lead_won_q;
  reg         slave_lead_won_q;
  wire [7:0]  channel_flags [0:3];

  // ****************************************************************
  // Host write buffer
  // ****************************************************************
  wire [14:0] wq_in = {host_bidir, host_chan, host_addr, host_wdata};
  wire [14:0] wq_out;
  wire        wq_valid;
  wire        wq_ready;
  // Slave writes own the cycle, so draining stalls and the buffer can fill
  wire        wq_take = wq_valid & wq_ready;

  assign wq_ready = ~slv_wr;

  lpcmb_fifo #(
    .WIDTH (15),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_wq (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (host_wr),
    .in_ready  (host_wr_ready),
    .in_data   (wq_in),
    .out_valid (wq_valid),
    .out_ready (wq_ready),
    .out_data  (wq_out)
  );

  // Fields of the drained host write
  wire        d_bidir = wq_out[14];
  wire [1:0]  d_chan  = wq_out[13:12];
  wire [3:0]  d_addr  = wq_out[11:8];
  wire [7:0]  d_data  = wq_out[7:0];
  wire        d_cmd   = d_addr[`LPCMB_A_CMD_BIT];
  wire        h_wr_in = wq_take & ~d_bidir;
  wire        h_wr_bd = wq_take & d_bidir;

  // Reads wait for queued writes so the host sees its own writes in order
  assign host_rd_ready = ~wq_valid;
  wire        h_rd    = host_rd & host_rd_ready;
  wire        h_rd_flags = h_rd & ~host_bidir & host_addr[`LPCMB_A_CMD_BIT];

  // Slave decode
  wire        s_bidir = slv_addr[4] == `LPCMB_GRP_BIDIR;
  wire [3:0]  s_idx   = slv_addr[3:0];
  wire [2:0]  s_grp   = slv_addr[4:2];
  wire [1:0]  s_ch    = slv_addr[1:0];

  // ****************************************************************
  // Per-channel flag registers
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_chan
      localparam [1:0] CH = g;
      wire in_set    = h_wr_in & (d_chan == CH);
      wire in_clr    = slv_rd & (s_grp == `LPCMB_GRP_IN) & (s_ch == CH);
      wire out_set   = slv_wr & (s_grp == `LPCMB_GRP_OUT) & (s_ch == CH);
      wire out_clr_h = h_rd & ~host_bidir & (host_chan == CH) & ~host_addr[`LPCMB_A_CMD_BIT];
      wire flags_wr  = slv_wr & (s_grp == `LPCMB_GRP_FLAGS) & (s_ch == CH);
      wire out_clr_s = flags_wr & ~slv_wdata[`LPCMB_F_OUT_FULL];

      assign channel_flags[g] = {user_flags_q[g][4:1], command_not_data_q[g],
                                 user_flags_q[g][0], input_full_flag_q[g], output_full_flag_q[g]};

      // Input byte is stored in the same cycle its flags move
      always @(posedge clk) begin
        if (in_set) begin
          host_input_byte[g] <= d_data;                   // [RULE15] [RULE17]
        end
        if (out_set) begin
          host_output_byte[g] <= slv_wdata;               // [RULE1] [RULE3]
        end
      end

      // Sets win over clears arriving in the same cycle
      always @(posedge clk) begin
        if (!nrst) begin
          input_full_flag_q[g]  <= 1'b0;
          output_full_flag_q[g] <= 1'b0;
          command_not_data_q[g] <= 1'b0;
          user_flags_q[g]       <= `LPCMB_USER_RST;
        end else begin
          if (in_set) begin
            input_full_flag_q[g]  <= 1'b1;                 // [RULE11] [RULE16] [RULE17]
            command_not_data_q[g] <= d_cmd;                // [RULE10] [RULE15]
          end else if (in_clr) begin
            input_full_flag_q[g]  <= 1'b0;                 // [RULE11]
          end
          if (out_set) begin
            output_full_flag_q[g] <= 1'b1;                 // [RULE13]
          end else if (out_clr_h | out_clr_s) begin
            output_full_flag_q[g] <= 1'b0;                 // [RULE13] [RULE14]
          end
          if (flags_wr) begin
            user_flags_q[g] <= {slv_wdata[`LPCMB_F_USER_HI:`LPCMB_F_USER_LO],
                                slv_wdata[`LPCMB_F_USER_TWO]};  // [RULE9]
          end
        end
      end
    end
  endgenerate

  // Input full doubles as the interrupt request line per channel
  assign slave_irq_req = input_full_flag_q;               // [RULE12]

  // ****************************************************************
  // Bidirectional bytes
  // ****************************************************************
  wire h_lead   = h_wr_bd & (d_addr == `LPCMB_BIDIR_LEAD);
  wire s_lead   = slv_wr & s_bidir & (s_idx == `LPCMB_BIDIR_LEAD);
  wire s_rd_end = slv_rd & s_bidir & (s_idx == `LPCMB_BIDIR_LAST);
  wire h_rd_end = h_rd & host_bidir & (host_addr == `LPCMB_BIDIR_LAST);

  // No reset on data; slave and drained host writes never share a cycle
  always @(posedge clk) begin
    if (h_wr_bd && d_addr != `LPCMB_BIDIR_LEAD) begin
      shared_bidir_byte[d_addr] <= d_data;                 // [RULE4] [RULE7] [RULE3]
    end else if (slv_wr && s_bidir && s_idx != `LPCMB_BIDIR_LEAD) begin
      shared_bidir_byte[s_idx] <= slv_wdata;               // [RULE4]
    end
    if (h_lead && !slave_lead_won_q) begin
      host_to_slave_lead_byte <= d_data;                   // [RULE5]
    end
    if (s_lead && !host_lead_won_q) begin
      slave_to_host_lead_byte <= slv_wdata;                // [RULE5]
    end
  end

  // Whoever writes byte 0 first owns it until the far side reads byte 15
  always @(posedge clk) begin
    if (!nrst) begin
      host_lead_won_q  <= 1'b0;
      slave_lead_won_q <= 1'b0;
    end else begin
      if (h_lead && !slave_lead_won_q) begin
        host_lead_won_q <= 1'b1;                           // [RULE6]
      end else if (s_rd_end) begin
        host_lead_won_q <= 1'b0;
      end
      if (s_lead && !host_lead_won_q) begin
        slave_lead_won_q <= 1'b1;                          // [RULE6]
      end else if (h_rd_end) begin
        slave_lead_won_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Host read path
  // ****************************************************************
  reg [7:0] host_rdata_d;

  // Bidirectional window, else flags on bit 2 high, else output byte
  always @* begin
    if (host_bidir) begin
      if (host_addr == `LPCMB_BIDIR_LEAD) begin
        host_rdata_d = slave_to_host_lead_byte;            // [RULE5]
      end else begin
        host_rdata_d = shared_bidir_byte[host_addr];       // [RULE7]
      end
    end else if (h_rd_flags) begin
      host_rdata_d = channel_flags[host_chan];             // [RULE8]
    end else begin
      host_rdata_d = host_output_byte[host_chan];          // [RULE2]
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      host_rdata_q  <= 8'h00;
      host_rvalid_q <= 1'b0;
    end else begin
      host_rvalid_q <= h_rd;
      if (h_rd) begin
        host_rdata_q <= host_rdata_d;
      end
    end
  end

  // ****************************************************************
  // Slave read path
  // ****************************************************************
  reg [7:0] slv_rdata_d;

  // Unmapped slave offsets read as zero
  always @* begin
    slv_rdata_d = 8'h00;
    if (s_bidir) begin
      if (s_idx == `LPCMB_BIDIR_LEAD) begin
        slv_rdata_d = host_to_slave_lead_byte;             // [RULE5]
      end else begin
        slv_rdata_d = shared_bidir_byte[s_idx];            // [RULE4]
      end
    end else begin
      case (s_grp)
        `LPCMB_GRP_IN: begin
          slv_rdata_d = host_input_byte[s_ch];
        end
        `LPCMB_GRP_OUT: begin
          slv_rdata_d = host_output_byte[s_ch];            // [RULE1]
        end
        `LPCMB_GRP_FLAGS: begin
          slv_rdata_d = channel_flags[s_ch];
        end
        default: begin
          if (slv_addr == `LPCMB_A_ARB) begin
            slv_rdata_d = {6'h00, slave_lead_won_q, host_lead_won_q};  // [RULE6]
          end
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (!nrst) begin
      slv_rdata_q  <= 8'h00;
      slv_rvalid_q <= 1'b0;
    end else begin
      slv_rvalid_q <= slv_rd;
      if (slv_rd) begin
        slv_rdata_q <= slv_rdata_d;
      end
    end
  end

endmodule

// >>> testbench/lpcmb_host_model.sv
// Host model: issues decoded LPC I/O write and read cycles to the mailbox.
// Assumes the bench calls its tasks one at a time; pins change at falling edges.
`timescale 1ns/1ps

module lpcmb_host_model (
  input  wire        clk,
  input  wire        host_wr_ready,
  input  wire        host_rd_ready,
  input  wire  [7:0] host_rdata_q,
  input  wire        host_rvalid_q,
  output logic       host_wr,
  output logic       host_rd,
  output logic       host_bidir,
  output logic [1:0] host_chan,
  output logic [3:0] host_addr,
  output logic [7:0] host_wdata
);
  // Idle bus at time zero
  initial begin
    {host_wr, host_rd, host_bidir, host_chan, host_addr, host_wdata} = '0;
  end

  // One write, held until the buffer takes it
  task automatic wr(input logic b, input logic [1:0] c, input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    {host_bidir, host_chan, host_addr, host_wdata} = {b, c, a, d};
    host_wr = 1'b1;
    do @(posedge clk); while (!host_wr_ready);
    @(negedge clk);
    host_wr = 1'b0;
    host_wdata = ~d; // Released data shows no stale byte
  endtask

  // One read; answer sampled in the cycle after the taking edge
  task automatic rd(input logic b, input logic [1:0] c, input logic [3:0] a, output logic [7:0] q);
    @(negedge clk);
    {host_bidir, host_chan, host_addr} = {b, c, a};
    host_rd = 1'b1;
    do @(posedge clk); while (!host_rd_ready);
    @(negedge clk);
    host_rd = 1'b0;
    q = host_rdata_q;
  endtask

  // Ten back-to-back bidirectional write attempts, counting those the buffer takes
  task automatic fill(output int n);
    n = 0;
    @(negedge clk);
    host_bidir = 1'b1;
    host_wr = 1'b1;
    repeat (10) begin
      host_addr = 4'(n + 1);
      host_wdata = 8'(8'hc0 + n);
      @(posedge clk);
      if (host_wr_ready) n++;
      @(negedge clk);
    end
    host_wr = 1'b0;
  endtask
endmodule

// >>> testbench/lpcmb_top_assertions.sv
// Checker of the mailbox register block, bound to its top module.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module lpcmb_top_assertions #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  input wire       clk,
  input wire       nrst,
  input wire       host_rd,
  input wire       host_rd_ready,
  input wire [7:0] host_rdata_q,
  input wire       host_rvalid_q,
  input wire       slv_wr,
  input wire       slv_rd,
  input wire [4:0] slv_addr,
  input wire [7:0] slv_rdata_q,
  input wire       slv_rvalid_q,
  input wire [3:0] slave_irq_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ****************************************
  // Read answers and flag relations
  // ****************************************
  property p_rd_answer; host_rd && host_rd_ready |=> host_rvalid_q; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("host read not answered");
  property p_rd_cause; host_rvalid_q |-> $past(host_rd && host_rd_ready); endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("host answer without read");
  property p_rdata_hold; !host_rvalid_q |-> $stable(host_rdata_q); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("host read byte moved");
  property p_slv_answer; slv_rd |=> slv_rvalid_q; endproperty
  a_slv_answer: assert property (p_slv_answer) else $error("slave read not answered");
  property p_slv_cause; $rose(slv_rvalid_q) |-> $past(slv_rd); endproperty
  a_slv_cause: assert property (p_slv_cause) else $error("slave answer without read");
  property p_irq_clear; slv_rd && slv_addr == 5'h00 && host_rd_ready |=> !slave_irq_req[0]; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("input full kept after read");
  // Input full may only rise when a host write waited in the buffer
  property p_irq_cause; $rose(slave_irq_req[0]) |-> $past(!host_rd_ready); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("input full without write");
  property p_flag_irq;
    slv_rd && slv_addr == 5'h08 && host_rd_ready && !slv_wr |=> slv_rdata_q[1] == slave_irq_req[0];
  endproperty
  a_flag_irq: assert property (p_flag_irq) else $error("request differs from flag");
  property p_reset_flags; $rose(nrst) |-> slave_irq_req == 4'h0 && !host_rvalid_q; endproperty
  a_reset_flags: assert property (p_reset_flags) else $error("flags not cleared by reset");
endmodule

bind lpcmb_top lpcmb_top_assertions #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) lpcmb_top_assertions_i (
  .clk(clk), .nrst(nrst), .host_rd(host_rd), .host_rd_ready(host_rd_ready), .host_rdata_q(host_rdata_q),
  .host_rvalid_q(host_rvalid_q), .slv_wr(slv_wr), .slv_rd(slv_rd), .slv_addr(slv_addr),
  .slv_rdata_q(slv_rdata_q), .slv_rvalid_q(slv_rvalid_q), .slave_irq_req(slave_irq_req));

// >>> testbench/lpcmb_top_test.sv
// Self-checking bench of the mailbox registers with a host model.
// Assumes 50 MHz clock, synchronous active-low reset, inputs driven at falling edges.
`timescale 1ns/1ps

module lpcmb_top_test;
  logic       clk;
  logic       nrst;
  logic       slv_wr;
  logic       slv_rd;
  logic [4:0] slv_addr;
  logic [7:0] slv_wdata;
  wire  [7:0] slv_rdata_q;
  wire        slv_rvalid_q;
  wire  [3:0] slave_irq_req;
  wire        host_wr, host_wr_ready, host_rd, host_rd_ready, host_bidir, host_rvalid_q;
  wire  [1:0] host_chan;
  wire  [3:0] host_addr;
  wire  [7:0] host_wdata, host_rdata_q;
  logic [7:0] q;
  int         fail_count, tests_run, cycles, n;

  lpcmb_top lpcmb_top_i (.clk(clk), .nrst(nrst), .host_wr(host_wr), .host_wr_ready(host_wr_ready),
    .host_rd(host_rd), .host_rd_ready(host_rd_ready), .host_bidir(host_bidir), .host_chan(host_chan),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q),
    .slv_wr(slv_wr), .slv_rd(slv_rd), .slv_addr(slv_addr), .slv_wdata(slv_wdata), .slv_rdata_q(slv_rdata_q),
    .slv_rvalid_q(slv_rvalid_q), .slave_irq_req(slave_irq_req));
  lpcmb_host_model lpcmb_host_model_i (.clk(clk), .host_wr_ready(host_wr_ready), .host_rd_ready(host_rd_ready),
    .host_rdata_q(host_rdata_q), .host_rvalid_q(host_rvalid_q), .host_wr(host_wr), .host_rd(host_rd),
    .host_bidir(host_bidir), .host_chan(host_chan), .host_addr(host_addr), .host_wdata(host_wdata));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic swr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    slv_addr = a;
    slv_wdata = d;
    slv_wr = 1'b1;
    @(negedge clk);
    slv_wr = 1'b0;
  endtask
  task automatic srd(input logic [4:0] a, output logic [7:0] r);
    @(negedge clk);
    slv_addr = a;
    slv_rd = 1'b1;
    @(negedge clk);
    slv_rd = 1'b0;
    r = slv_rdata_q;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Clock and hang guard; a run well above the expected few hundred cycles is a hang
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {nrst, slv_wr, slv_rd, slv_addr, slv_wdata} = '0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    srd(5'h08, q); chk("flags reset", q, 8'h00);
    lpcmb_host_model_i.rd(0, 0, 4'h4, q); chk("host flags reset", q, 8'h00);
    swr(5'h04, 8'ha5); srd(5'h08, q); chk("out full set", q, 8'h01);
    srd(5'h04, q); chk("slave out byte", q, 8'ha5);
    lpcmb_host_model_i.rd(0, 0, 4'h0, q); chk("host out byte", q, 8'ha5);
    srd(5'h08, q); chk("out full cleared", q, 8'h00);
    swr(5'h04, 8'h5a); swr(5'h08, 8'hf5); srd(5'h08, q); chk("user bits, one ignored", q, 8'hf5);
    swr(5'h08, 8'hf4); srd(5'h08, q); chk("zero clears out full", q, 8'hf4);
    lpcmb_host_model_i.rd(0, 0, 4'h4, q); chk("host sees user bits", q, 8'hf4);
    $display("test output and user flags done");
    lpcmb_host_model_i.wr(0, 0, 4'h4, 8'h3c);
    lpcmb_host_model_i.rd(0, 0, 4'h4, q); chk("command write flags", q, 8'hfe);
    chk("irq raised", {4'h0, slave_irq_req}, 8'h01);
    srd(5'h00, q); chk("input byte", q, 8'h3c);
    srd(5'h08, q); chk("input full cleared", q, 8'hfc);
    lpcmb_host_model_i.wr(0, 0, 4'h0, 8'hc3); srd(5'h08, q); chk("data write flags", q, 8'hf6);
    srd(5'h00, q); chk("data byte", q, 8'hc3);
    for (int c = 1; c < 4; c++) begin
      lpcmb_host_model_i.wr(0, 2'(c), 4'h0, 8'(c));
      // The queued write lands an edge after it is taken, so look after a flags read
      srd(5'(8 + c), q); chk("channel flags", q, 8'h02);
      chk("channel irq", {4'h0, slave_irq_req}, 8'(1 << c));
      srd(5'(c), q); chk("channel input", q, 8'(c));
    end
    $display("test input flags done");
    for (int i = 1; i < 16; i++) begin
      lpcmb_host_model_i.wr(1, 0, 4'(i), 8'(8'h10 + i)); srd(5'(16 + i), q); chk("bidir host", q, 8'(8'h10 + i));
      swr(5'(16 + i), 8'(8'h80 + i)); lpcmb_host_model_i.rd(1, 0, 4'(i), q); chk("bidir slave", q, 8'(8'h80 + i));
    end
    swr(5'h10, 8'h77); srd(5'h0c, q); chk("slave won", q, 8'h02);
    lpcmb_host_model_i.rd(1, 0, 4'h0, q); chk("slave lead byte", q, 8'h77);
    lpcmb_host_model_i.wr(1, 0, 4'h0, 8'h5a); lpcmb_host_model_i.rd(1, 0, 4'hf, q);
    srd(5'h0c, q); chk("lost write leaves flags", q, 8'h00);
    lpcmb_host_model_i.wr(1, 0, 4'h0, 8'ha6); srd(5'h10, q); chk("host lead byte", q, 8'ha6);
    srd(5'h0c, q); chk("host won", q, 8'h01);
    srd(5'h0d, q); chk("unmapped", q, 8'h00);
    $display("test bidirectional done");
    @(negedge clk);
    slv_addr = 5'h05;
    slv_wdata = 8'h99;
    slv_wr = 1'b1;
    lpcmb_host_model_i.fill(n);
    slv_wr = 1'b0;
    chk("accepted beats", 8'(n), 8'h08);
    lpcmb_host_model_i.rd(1, 0, 4'h8, q); chk("last queued byte", q, 8'hc7);
    srd(5'h11, q); chk("first queued byte", q, 8'hc0);
    lpcmb_host_model_i.rd(0, 1, 4'h0, q); chk("stalling slave byte", q, 8'h99);
    srd(5'h09, q); chk("channel out full cleared", q, 8'h00);
    $display("test buffer done");
    end_of_test();
  end
endmodule
